/* rtl/fls_defines.svh */
// command codes, reset values, action and exponent codes and timing constants for the fault limit bank
// Operation
// R01: output below warning threshold at 43h raises output-low warning, default 0.44V.
// R02: output below word threshold at 44h declares undervoltage fault, default 0.395V.
// R03: undervoltage fault response at 45h is ignore or shutdown, default ignore.
// R04: output current above 46h limit signals overcurrent fault, 0.5A steps, exponent -1.
// R05: output current above 4Ah limit raises overcurrent warning, default 7.5A.
// R06: temperature reaching 4Fh limit declares overtemperature fault, default 145C, exponent 0.
// R07: overtemperature response at 50h is ignore, shutdown or inhibit, default inhibit.
// R08: temperature reaching 51h limit raises overtemperature warning, default 125C.
// R09: input voltage above 55h limit declares input overvoltage fault, default 24V.
// R10: input overvoltage response at 56h is ignore or shutdown, default shutdown.
// R11: power stage input voltage compared against 58h limit, default 0.5V, exponent -1.
// R12: power good asserts when output rises to 5Eh level scaled by loop factor.
// R13: power good negates when output falls to 5Fh level scaled by loop factor.
// R14: after start condition wait 60h delay in milliseconds before output rises.
// R15: output ramps into regulation over 61h time in milliseconds, default 2ms.
// R16: output not reaching undervoltage limit within 62h time gives turn-on timeout fault.
// R17: turn-on timeout response at 63h is ignore or shutdown, default ignore.
// R18: turn-off delay and fall commands are acknowledged but have no effect.
// R19: start and stop conditions come from enable pin and bus on/off combination.
// R20: loop scale factor is 1, 0.5, 0.25 or 0.125 and multiplies scaled levels.
// R21: ignored faults keep conversion running but are still recorded.
// R22: host writes thresholds in linear format with each command's permitted exponent.
`ifndef FLS_DEFINES_SVH
`define FLS_DEFINES_SVH
`define FLS_CMD_OUT_LOW_WARN 8'h43
`define FLS_CMD_OUT_UV_FAULT 8'h44
`define FLS_CMD_OUT_UV_ACT 8'h45
`define FLS_CMD_OC_FAULT 8'h46
`define FLS_CMD_OC_ACT 8'h47
`define FLS_CMD_OC_WARN 8'h4A
`define FLS_CMD_OT_FAULT 8'h4F
`define FLS_CMD_OT_ACT 8'h50
`define FLS_CMD_OT_WARN 8'h51
`define FLS_CMD_VIN_OV_FAULT 8'h55
`define FLS_CMD_VIN_OV_ACT 8'h56
`define FLS_CMD_VIN_LOW_WARN 8'h58
`define FLS_CMD_PG_ON 8'h5E
`define FLS_CMD_PG_OFF 8'h5F
`define FLS_CMD_TURN_ON_DELAY_TIME 8'h60
`define FLS_CMD_TON_RAMP 8'h61
`define FLS_CMD_TON_MAX 8'h62
`define FLS_CMD_TON_MAX_ACT 8'h63
`define FLS_CMD_TURN_OFF_DELAY_UNUSED 8'h64
`define FLS_CMD_TURN_OFF_FALL_UNUSED 8'h65
`define FLS_RST_OUT_LOW_WARN 16'h0071
`define FLS_RST_OUT_UV_FAULT 16'h0065
`define FLS_RST_OC_FAULT 16'hF814
`define FLS_RST_OC_WARN 16'hF80F
`define FLS_RST_OT_FAULT 16'h0091
`define FLS_RST_OT_WARN 16'h007D
`define FLS_RST_VIN_OV_FAULT 16'hF060
`define FLS_RST_VIN_LOW_WARN 16'hF801
`define FLS_RST_PG_ON 16'h0073
`define FLS_RST_PG_OFF 16'h006B
`define FLS_RST_TURN_ON_DELAY_TIME 16'h0000
`define FLS_RST_TON_RAMP 16'h0002
`define FLS_RST_TON_MAX 16'h0005
`define FLS_RST_TURN_OFF_DELAY_UNUSED 16'h0000
`define FLS_RST_TURN_OFF_FALL_UNUSED 16'h0001
`define FLS_ACT_IGNORE 8'h00
`define FLS_ACT_SHUTDOWN 8'h80
`define FLS_ACT_INHIBIT 8'hC0
`define FLS_EXP_0 5'h00
`define FLS_EXP_M1 5'h1F
`define FLS_EXP_M2 5'h1E
`define FLS_CLK_HZ 200000000
`define FLS_TIME_STEP_MS 1
`endif

/* rtl/fls_fault_limit_bank.sv */
// fault and warning limits, fault responses and power-up sequencer
`timescale 1ns/10ps
`include "fls_defines.svh"
module fls_fault_limit_bank #(
  parameter int MS_CYCLES = `FLS_CLK_HZ / 1000 * `FLS_TIME_STEP_MS,
  parameter int PRE_W = 18
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // command port from the bus transaction layer
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic rsp_invalid,
  output logic [15:0] rsp_rdata,
  // on/off and loop scale
  input wire logic start_cond,
  input wire logic [1:0] scale_loop_shift,
  input wire logic clear_faults,
  // measurements
  input wire logic [15:0] vout_sense,
  input wire logic [10:0] iout_meas,
  input wire logic [10:0] temp_meas,
  input wire logic [10:0] power_stage_input_voltage,
  // power stage control and status
  output logic conv_enable,
  output logic ramp_active,
  output logic power_good,
  output logic out_low_warn,
  output logic out_uv_fault,
  output logic oc_fault,
  output logic oc_warn,
  output logic ot_fault,
  output logic ot_warn,
  output logic vin_ov_fault,
  output logic vin_low_warn,
  output logic ton_max_fault
);

  localparam int NREG = 20;

  // command code to storage slot, NREG when unsupported
  function automatic logic [4:0] slot_of(input logic [7:0] c);
    if (c == `FLS_CMD_OUT_LOW_WARN) slot_of = 5'h00;
    else if (c == `FLS_CMD_OUT_UV_FAULT) slot_of = 5'h01;
    else if (c == `FLS_CMD_OUT_UV_ACT) slot_of = 5'h02;
    else if (c == `FLS_CMD_OC_FAULT) slot_of = 5'h03;
    else if (c == `FLS_CMD_OC_ACT) slot_of = 5'h04;
    else if (c == `FLS_CMD_OC_WARN) slot_of = 5'h05;
    else if (c == `FLS_CMD_OT_FAULT) slot_of = 5'h06;
    else if (c == `FLS_CMD_OT_ACT) slot_of = 5'h07;
    else if (c == `FLS_CMD_OT_WARN) slot_of = 5'h08;
    else if (c == `FLS_CMD_VIN_OV_FAULT) slot_of = 5'h09;
    else if (c == `FLS_CMD_VIN_OV_ACT) slot_of = 5'h0A;
    else if (c == `FLS_CMD_VIN_LOW_WARN) slot_of = 5'h0B;
    else if (c == `FLS_CMD_PG_ON) slot_of = 5'h0C;
    else if (c == `FLS_CMD_PG_OFF) slot_of = 5'h0D;
    else if (c == `FLS_CMD_TURN_ON_DELAY_TIME) slot_of = 5'h0E;
    else if (c == `FLS_CMD_TON_RAMP) slot_of = 5'h0F;
    else if (c == `FLS_CMD_TON_MAX) slot_of = 5'h10;
    else if (c == `FLS_CMD_TON_MAX_ACT) slot_of = 5'h11;
    else if (c == `FLS_CMD_TURN_OFF_DELAY_UNUSED) slot_of = 5'h12;
    else if (c == `FLS_CMD_TURN_OFF_FALL_UNUSED) slot_of = 5'h13;
    else slot_of = 5'(NREG);
  endfunction : slot_of

  // reset value of each slot
  function automatic logic [15:0] reset_of(input int s);
    case (s)
      0: reset_of = `FLS_RST_OUT_LOW_WARN;
      1: reset_of = `FLS_RST_OUT_UV_FAULT;
      2: reset_of = {8'h00, `FLS_ACT_IGNORE};
      3: reset_of = `FLS_RST_OC_FAULT;
      4: reset_of = {8'h00, `FLS_ACT_SHUTDOWN};
      5: reset_of = `FLS_RST_OC_WARN;
      6: reset_of = `FLS_RST_OT_FAULT;
      7: reset_of = {8'h00, `FLS_ACT_INHIBIT};
      8: reset_of = `FLS_RST_OT_WARN;
      9: reset_of = `FLS_RST_VIN_OV_FAULT;
      10: reset_of = {8'h00, `FLS_ACT_SHUTDOWN};
      11: reset_of = `FLS_RST_VIN_LOW_WARN;
      12: reset_of = `FLS_RST_PG_ON;
      13: reset_of = `FLS_RST_PG_OFF;
      14: reset_of = `FLS_RST_TURN_ON_DELAY_TIME;
      15: reset_of = `FLS_RST_TON_RAMP;
      16: reset_of = `FLS_RST_TON_MAX;
      17: reset_of = {8'h00, `FLS_ACT_IGNORE};
      18: reset_of = `FLS_RST_TURN_OFF_DELAY_UNUSED;
      19: reset_of = `FLS_RST_TURN_OFF_FALL_UNUSED;
      default: reset_of = 16'h0000;
    endcase
  endfunction : reset_of

  // byte-wide response slots
  function automatic logic is_byte(input logic [4:0] s);
    is_byte = (s == 5'h02) || (s == 5'h04) || (s == 5'h07) || (s == 5'h0A) || (s == 5'h11);
  endfunction : is_byte

  // write data check: exponent of linear11 words, action code of bytes except 47h
  function automatic logic data_ok(input logic [4:0] s, input logic [15:0] d);
    logic [4:0] e;
    e = d[15:11];
    case (s)
      5'h03, 5'h05, 5'h0B: data_ok = (e == `FLS_EXP_M1);
      5'h06, 5'h08, 5'h0E, 5'h0F, 5'h10, 5'h12, 5'h13: data_ok = (e == `FLS_EXP_0);
      5'h09: data_ok = (e == `FLS_EXP_M2);
      5'h02, 5'h0A, 5'h11: data_ok = (d[7:0] == `FLS_ACT_IGNORE) || (d[7:0] == `FLS_ACT_SHUTDOWN);
      5'h07: data_ok = (d[7:0] == `FLS_ACT_IGNORE) || (d[7:0] == `FLS_ACT_SHUTDOWN) ||
                       (d[7:0] == `FLS_ACT_INHIBIT);
      default: data_ok = 1'b1;
    endcase
  endfunction : data_ok

  // register storage
  logic [15:0] cfg_reg [0:NREG-1];

  // command decode
  wire [4:0] cmd_slot = slot_of(cmd_code);
  wire cmd_known = (cmd_slot != 5'(NREG));
  wire cmd_good = cmd_known && data_ok(cmd_slot, cmd_wdata); // see R22
  wire cmd_store = cmd_valid && cmd_write && cmd_good; // see R18
  wire [15:0] store_val = is_byte(cmd_slot) ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
  wire [15:0] read_val = cmd_known ? cfg_reg[cmd_slot] : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_cfg
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          cfg_reg[gi] <= reset_of(gi);
        end else if (cmd_store && (cmd_slot == 5'(gi))) begin
          cfg_reg[gi] <= store_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_invalid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_ack <= cmd_valid && cmd_known;
      rsp_invalid <= cmd_valid && cmd_write && cmd_known && !cmd_good;
      rsp_rdata <= (cmd_valid && !cmd_write) ? read_val : 16'h0000;
    end
  end

  // limit fields
  wire [15:0] lim_out_low = cfg_reg[0];
  wire [15:0] lim_out_uv = cfg_reg[1];
  wire [10:0] lim_oc = cfg_reg[3][10:0];
  wire [10:0] lim_oc_warn = cfg_reg[5][10:0];
  wire [10:0] lim_ot = cfg_reg[6][10:0];
  wire [10:0] lim_ot_warn = cfg_reg[8][10:0];
  wire [10:0] lim_vin_ov = cfg_reg[9][10:0];
  wire [11:0] lim_vin_low = {cfg_reg[11][10:0], 1'b0};
  wire [15:0] pg_on_scaled = cfg_reg[12] >> scale_loop_shift; // see R20
  wire [15:0] pg_off_scaled = cfg_reg[13] >> scale_loop_shift; // see R20
  wire [10:0] turn_on_delay_time_ms = cfg_reg[14][10:0];
  wire [10:0] ton_ramp_ms = cfg_reg[15][10:0];
  wire [10:0] ton_max_ms = cfg_reg[16][10:0];
  wire [1:0] act_uv = cfg_reg[2][7:6];
  wire [1:0] act_ot = cfg_reg[7][7:6];
  wire [1:0] act_vin = cfg_reg[10][7:6];
  wire [1:0] act_ton = cfg_reg[17][7:6];

  // sequencer state
  fls_pkg::fls_seq_t seq_reg;
  fls_pkg::fls_seq_t seq_next;
  logic [PRE_W-1:0] pre_reg;
  logic [10:0] phase_ms_reg;
  logic [10:0] max_ms_reg;
  logic reached_uv_reg;
  logic ton_max_done_reg;

  wire running = (seq_reg == fls_pkg::FLS_SEQ_RAMP) || (seq_reg == fls_pkg::FLS_SEQ_ON);
  wire timing = running || (seq_reg == fls_pkg::FLS_SEQ_DELAY);
  wire ms_tick = timing && (pre_reg == PRE_W'(MS_CYCLES - 1));

  // live conditions
  wire c_out_low = vout_sense < lim_out_low; // see R01
  wire c_out_uv = (seq_reg == fls_pkg::FLS_SEQ_ON) && reached_uv_reg &&
                  (vout_sense < lim_out_uv); // see R02
  wire c_oc = iout_meas > lim_oc; // see R04
  wire c_oc_warn = iout_meas > lim_oc_warn; // see R05
  wire c_ot = temp_meas >= lim_ot; // see R06
  wire c_ot_warn = temp_meas >= lim_ot_warn; // see R08
  wire c_vin_ov = power_stage_input_voltage > lim_vin_ov; // see R09
  wire c_vin_low = {1'b0, power_stage_input_voltage} < lim_vin_low; // see R11
  wire c_ton_max = running && !reached_uv_reg && !ton_max_done_reg &&
                   (max_ms_reg >= ton_max_ms); // see R16

  // responses
  wire shut_uv = c_out_uv && (act_uv == fls_pkg::FLS_RSP_SHUTDOWN); // see R03
  wire shut_vin = c_vin_ov && (act_vin == fls_pkg::FLS_RSP_SHUTDOWN); // see R10
  wire shut_ton = c_ton_max && (act_ton == fls_pkg::FLS_RSP_SHUTDOWN); // see R17
  wire shut_ot = c_ot && (act_ot == fls_pkg::FLS_RSP_SHUTDOWN); // see R07
  wire inhibit_ot = c_ot && (act_ot == fls_pkg::FLS_RSP_INHIBIT); // see R07
  wire shut_any = shut_uv || shut_vin || shut_ton || shut_ot;

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      fls_pkg::FLS_SEQ_OFF: begin
        if (start_cond && !inhibit_ot && !shut_vin && !shut_ot) begin // see R19
          seq_next = fls_pkg::FLS_SEQ_DELAY;
        end
      end
      fls_pkg::FLS_SEQ_DELAY: begin
        if (!start_cond) begin // see R19
          seq_next = fls_pkg::FLS_SEQ_OFF;
        end else if (shut_any) begin
          seq_next = fls_pkg::FLS_SEQ_LATCHED;
        end else if (inhibit_ot) begin
          seq_next = fls_pkg::FLS_SEQ_OFF;
        end else if (phase_ms_reg >= turn_on_delay_time_ms) begin // see R14
          seq_next = fls_pkg::FLS_SEQ_RAMP;
        end
      end
      fls_pkg::FLS_SEQ_RAMP, fls_pkg::FLS_SEQ_ON: begin
        if (!start_cond) begin
          seq_next = fls_pkg::FLS_SEQ_OFF;
        end else if (shut_any) begin // see R21
          seq_next = fls_pkg::FLS_SEQ_LATCHED;
        end else if (inhibit_ot) begin
          seq_next = fls_pkg::FLS_SEQ_OFF;
        end else if ((seq_reg == fls_pkg::FLS_SEQ_RAMP) && (phase_ms_reg >= ton_ramp_ms)) begin
          seq_next = fls_pkg::FLS_SEQ_ON; // see R15
        end
      end
      fls_pkg::FLS_SEQ_LATCHED: begin
        if (!start_cond) begin
          seq_next = fls_pkg::FLS_SEQ_OFF;
        end
      end
      default: seq_next = fls_pkg::FLS_SEQ_OFF;
    endcase
  end

  wire seq_change = (seq_next != seq_reg);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seq_reg <= fls_pkg::FLS_SEQ_OFF;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // millisecond prescaler and phase timer, restarted on every state change
  always_ff @(posedge ref_clk) begin
    if (srst || seq_change || ms_tick || !timing) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || seq_change) begin
      phase_ms_reg <= 11'h000;
    end else if (ms_tick && (phase_ms_reg != 11'h7FF)) begin
      phase_ms_reg <= phase_ms_reg + 11'h001; // see R14 R15
    end
  end

  // turn-on timeout window starts with the rise
  wire rise_start = (seq_reg == fls_pkg::FLS_SEQ_DELAY) && (seq_next == fls_pkg::FLS_SEQ_RAMP);

  always_ff @(posedge ref_clk) begin
    if (srst || rise_start) begin
      max_ms_reg <= 11'h000;
      reached_uv_reg <= 1'b0;
      ton_max_done_reg <= 1'b0;
    end else begin
      if (running && ms_tick && (max_ms_reg != 11'h7FF)) begin
        max_ms_reg <= max_ms_reg + 11'h001; // see R16
      end
      if (running && (vout_sense >= lim_out_uv)) begin
        reached_uv_reg <= 1'b1;
      end
      if (c_ton_max) begin
        ton_max_done_reg <= 1'b1;
      end
    end
  end

  // power good with on/off hysteresis
  wire pg_set = running && (vout_sense >= pg_on_scaled); // see R12
  wire pg_clr = !running || (vout_sense <= pg_off_scaled); // see R13
  wire pg_next = power_good ? !pg_clr : pg_set;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      power_good <= 1'b0;
      conv_enable <= 1'b0;
      ramp_active <= 1'b0;
    end else begin
      power_good <= pg_next;
      conv_enable <= (seq_next == fls_pkg::FLS_SEQ_RAMP) || (seq_next == fls_pkg::FLS_SEQ_ON);
      ramp_active <= (seq_next == fls_pkg::FLS_SEQ_RAMP); // see R15
    end
  end

  // sticky fault and warning record, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_low_warn <= 1'b0;
      out_uv_fault <= 1'b0;
      oc_fault <= 1'b0;
      oc_warn <= 1'b0;
      ot_fault <= 1'b0;
      ot_warn <= 1'b0;
      vin_ov_fault <= 1'b0;
      vin_low_warn <= 1'b0;
      ton_max_fault <= 1'b0;
    end else begin
      out_low_warn <= c_out_low || (out_low_warn && !clear_faults); // see R01 R21
      out_uv_fault <= c_out_uv || (out_uv_fault && !clear_faults); // see R02 R21
      oc_fault <= c_oc || (oc_fault && !clear_faults); // see R04
      oc_warn <= c_oc_warn || (oc_warn && !clear_faults); // see R05
      ot_fault <= c_ot || (ot_fault && !clear_faults); // see R06 R21
      ot_warn <= c_ot_warn || (ot_warn && !clear_faults); // see R08
      vin_ov_fault <= c_vin_ov || (vin_ov_fault && !clear_faults); // see R09 R21
      vin_low_warn <= c_vin_low || (vin_low_warn && !clear_faults); // see R11
      ton_max_fault <= c_ton_max || (ton_max_fault && !clear_faults); // see R16 R21
    end
  end

endmodule : fls_fault_limit_bank

/* rtl/fls_pkg.sv */
// types shared by the fault limit bank
package fls_pkg;
  typedef enum logic [2:0] {
    FLS_SEQ_OFF = 3'b000,
    FLS_SEQ_DELAY = 3'b001,
    FLS_SEQ_RAMP = 3'b010,
    FLS_SEQ_ON = 3'b011,
    FLS_SEQ_LATCHED = 3'b100
  } fls_seq_t;
  typedef enum logic [1:0] {
    FLS_RSP_IGNORE = 2'b00,
    FLS_RSP_SHUTDOWN = 2'b10,
    FLS_RSP_INHIBIT = 2'b11
  } fls_rsp_t;
endpackage : fls_pkg

/* sim/fls_fault_limit_bank_bench.sv */
// self-checking bench for the fault limit bank
`timescale 1ns/10ps
module fls_fault_limit_bank_bench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic start_cond = 1'b0;
  logic clear_faults = 1'b0;
  logic [1:0] scale = 2'h0;
  logic [15:0] vout = 16'h0000;
  logic [10:0] iout = 11'h000;
  logic [10:0] temp = 11'h000;
  logic [10:0] vin = 11'h014;
  wire cmd_valid, cmd_write, rsp_valid, rsp_ack, rsp_invalid, conv_enable, ramp_active;
  wire power_good;
  wire [7:0] cmd_code;
  wire [15:0] cmd_wdata, rsp_rdata;
  wire [8:0] flags;
  wire [3:0] st = {conv_enable, ramp_active, power_good, flags[0]};
  int mismatches = 0;
  int compares = 0;
  logic [7:0] codes [20] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h4F, 8'h50, 8'h51,
    8'h55, 8'h56, 8'h58, 8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
  logic [15:0] dflt [20] = '{16'h0071, 16'h0065, 16'h0000, 16'hF814, 16'h0080, 16'hF80F,
    16'h0091, 16'h00C0, 16'h007D, 16'hF060, 16'h0080, 16'hF801, 16'h0073, 16'h006B,
    16'h0000, 16'h0002, 16'h0005, 16'h0000, 16'h0000, 16'h0001};
  logic [15:0] wval [20] = '{16'h0080, 16'h0070, 16'h0080, 16'hF80C, 16'h0000, 16'hF80B,
    16'h0064, 16'h0080, 16'h0050, 16'hF030, 16'h0000, 16'hF806, 16'h0060, 16'h0058,
    16'h0003, 16'h0004, 16'h0007, 16'h0080, 16'h0009, 16'h000A};
  always #2.5 ref_clk = ~ref_clk;
  fls_host_model i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_invalid(rsp_invalid), .rsp_rdata(rsp_rdata));
  fls_fault_limit_bank #(.MS_CYCLES(10)) i_dut (.ref_clk(ref_clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_invalid(rsp_invalid), .rsp_rdata(rsp_rdata), .start_cond(start_cond),
    .scale_loop_shift(scale), .clear_faults(clear_faults), .vout_sense(vout),
    .iout_meas(iout), .temp_meas(temp), .power_stage_input_voltage(vin),
    .conv_enable(conv_enable), .ramp_active(ramp_active), .power_good(power_good),
    .out_low_warn(flags[8]), .out_uv_fault(flags[7]), .oc_fault(flags[6]),
    .oc_warn(flags[5]), .ot_fault(flags[4]), .ot_warn(flags[3]), .vin_ov_fault(flags[2]),
    .vin_low_warn(flags[1]), .ton_max_fault(flags[0]));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_st(input int idx, input logic val, input int lim);
    int k;
    for (k = 0; k < lim && st[idx] !== val; k++) @(negedge ref_clk);
    chk(16'(k == lim), 16'h0000, "status wait");
    if (k == lim) end_sim();
  endtask : wait_st
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] data,
      input logic [2:0] er, input logic [15:0] ed);
    logic [2:0] r;
    logic [15:0] rd;
    i_host.xfer(wr, code, data, r, rd);
    chk({13'h0, r}, {13'h0, er}, "answer bits");
    if (!wr) chk(rd, ed, "read data");
  endtask : cmd
  task automatic do_reset();
    srst = 1'b1;
    start_cond = 1'b0;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
  endtask : do_reset
  task automatic t_regs();
    logic [7:0] act [3] = '{8'h00, 8'h80, 8'hC0};
    for (int i = 0; i < 20; i++) begin
      cmd(1'b0, codes[i], 16'h0000, 3'b110, dflt[i]);
      cmd(1'b1, codes[i], wval[i], 3'b110, 16'h0000);
      cmd(1'b0, codes[i], 16'h0000, 3'b110, wval[i]);
    end
    foreach (act[j]) begin
      cmd(1'b1, 8'h50, {8'h00, act[j]}, 3'b110, 16'h0000);
      cmd(1'b0, 8'h50, 16'h0000, 3'b110, {8'h00, act[j]});
    end
    cmd(1'b1, 8'h45, 16'h00C0, 3'b111, 16'h0000);
    cmd(1'b1, 8'h60, 16'hF805, 3'b111, 16'h0000);
    cmd(1'b1, 8'h55, 16'hF830, 3'b111, 16'h0000);
    cmd(1'b0, 8'h60, 16'h0000, 3'b110, 16'h0003);
    cmd(1'b0, 8'h40, 16'h0000, 3'b100, 16'h0000);
    $display("test registers done");
  endtask : t_regs
  task automatic t_limits();
    do_reset();
    vout = 16'h0080;
    cmd(1'b1, 8'h46, 16'hF80A, 3'b110, 16'h0000);
    cmd(1'b1, 8'h4A, 16'hF808, 3'b110, 16'h0000);
    cmd(1'b1, 8'h51, 16'h0032, 3'b110, 16'h0000);
    cmd(1'b1, 8'h55, 16'hF028, 3'b110, 16'h0000);
    iout = 11'h00A;
    temp = 11'h031;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, flags}, 16'h0020, "flags at limits");
    iout = 11'h00B;
    temp = 11'h032;
    vin = 11'h029;
    vout = 16'h0070;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, flags}, 16'h016C, "flags over limits");
    vin = 11'h001;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, flags}, 16'h016E, "input low");
    {iout, temp, vin, vout} = {11'h000, 11'h000, 11'h014, 16'h0080};
    clear_faults = 1'b1;
    @(negedge ref_clk);
    clear_faults = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, flags}, 16'h0000, "flags cleared");
    $display("test limits done");
  endtask : t_limits
  task automatic t_seq();
    int k;
    do_reset();
    scale = 2'h0;
    cmd(1'b1, 8'h60, 16'h0002, 3'b110, 16'h0000);
    cmd(1'b1, 8'h61, 16'h0003, 3'b110, 16'h0000);
    start_cond = 1'b1;
    for (k = 0; k < 100 && conv_enable !== 1'b1; k++) @(negedge ref_clk);
    chk(16'(k), 16'h0016, "turn-on delay");
    for (k = 0; k < 100 && ramp_active === 1'b1; k++) @(negedge ref_clk);
    chk(16'(k), 16'h001F, "rise time");
    wait_st(1, 1'b1, 20);
    vout = 16'h0040;
    wait_st(1, 1'b0, 20);
    repeat (2) @(negedge ref_clk);
    chk({14'h0, conv_enable, flags[7]}, 16'h0003, "undervoltage ignored");
    scale = 2'h1;
    wait_st(1, 1'b1, 20);
    start_cond = 1'b0;
    wait_st(3, 1'b0, 5);
    $display("test sequence done");
  endtask : t_seq
  task automatic t_faults();
    do_reset();
    vout = 16'h0000;
    cmd(1'b1, 8'h62, 16'h0001, 3'b110, 16'h0000);
    cmd(1'b1, 8'h63, 16'h0080, 3'b110, 16'h0000);
    start_cond = 1'b1;
    wait_st(0, 1'b1, 100);
    wait_st(3, 1'b0, 5);
    repeat (30) @(negedge ref_clk);
    chk({15'h0, conv_enable}, 16'h0000, "latched off");
    do_reset();
    vout = 16'h0080;
    cmd(1'b1, 8'h4F, 16'h0040, 3'b110, 16'h0000);
    temp = 11'h040;
    @(negedge ref_clk);
    start_cond = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk({14'h0, conv_enable, flags[4]}, 16'h0001, "inhibited");
    temp = 11'h014;
    clear_faults = 1'b1;
    @(negedge ref_clk);
    clear_faults = 1'b0;
    wait_st(3, 1'b1, 50);
    $display("test faults done");
  endtask : t_faults
  initial begin
    do_reset();
    t_regs();
    t_limits();
    t_seq();
    t_faults();
    end_sim();
  end
endmodule : fls_fault_limit_bank_bench

/* sim/fls_fault_limit_bank_props.sv */
// port assertions for the fault limit bank
`timescale 1ns/10ps
module fls_fault_limit_bank_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic rsp_invalid,
  input wire logic [15:0] rsp_rdata,
  // sequencing and flags
  input wire logic start_cond,
  input wire logic clear_faults,
  input wire logic conv_enable,
  input wire logic ramp_active,
  input wire logic out_low_warn,
  input wire logic ot_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_taken; cmd_valid; endsequence
  sequence s_toff; cmd_valid && (cmd_code == 8'h64 || cmd_code == 8'h65); endsequence
  sequence s_unsup; cmd_valid && (cmd_code < 8'h43 || cmd_code > 8'h65); endsequence
  property p_answer; s_taken |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after command");
  property p_quiet; !cmd_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without command");
  property p_toff; s_toff |=> rsp_ack && !rsp_invalid; endproperty
  a_toff: assert property (p_toff) else $error("turn-off command not acked");
  property p_unsup; s_unsup |=> !rsp_ack && !rsp_invalid && rsp_rdata == 16'h0000; endproperty
  a_unsup: assert property (p_unsup) else $error("unknown code acked");
  property p_refuse; rsp_invalid |-> rsp_valid && rsp_ack; endproperty
  a_refuse: assert property (p_refuse) else $error("refusal without ack");
  property p_stop; !start_cond |-> ##[1:2] !conv_enable; endproperty
  a_stop: assert property (p_stop) else $error("output kept on without start");
  property p_start; $rose(conv_enable) |-> $past(start_cond) && $past(start_cond, 2); endproperty
  a_start: assert property (p_start) else $error("output rose without start");
  property p_ramp; ramp_active |-> conv_enable; endproperty
  a_ramp: assert property (p_ramp) else $error("rise phase with stage off");
  property p_low_keep; out_low_warn && !clear_faults |=> out_low_warn; endproperty
  a_low_keep: assert property (p_low_keep) else $error("low warning lost");
  property p_ot_keep; ot_fault && !clear_faults |=> ot_fault; endproperty
  a_ot_keep: assert property (p_ot_keep) else $error("overheat fault lost");
endmodule : fls_fault_limit_bank_props
bind fls_fault_limit_bank fls_fault_limit_bank_props i_props (
  .ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_invalid(rsp_invalid),
  .rsp_rdata(rsp_rdata), .start_cond(start_cond), .clear_faults(clear_faults),
  .conv_enable(conv_enable), .ramp_active(ramp_active), .out_low_warn(out_low_warn),
  .ot_fault(ot_fault));

/* sim/fls_host_model.sv */
// command-issuing host model for the fault limit bank
`timescale 1ns/10ps
module fls_host_model (
  // clock
  input wire logic ref_clk,
  // command side
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // answer side
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic rsp_invalid,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one command per call, answer taken on the falling edge half a cycle after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
      output logic [2:0] rsp, output logic [15:0] rdata);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    // released lines must not keep the old value
    cmd_code = ~code;
    cmd_wdata = ~data;
    rsp = {rsp_valid, rsp_ack, rsp_invalid};
    rdata = rsp_rdata;
  endtask : xfer
endmodule : fls_host_model
